/* File: gpevs_pkg.sv */
// package for the gpio event status and software-set block
// assumes a 32-bit apb slave, 16 event lines on bits 31..16
package gpevs_pkg;

    // register byte offsets
    localparam logic [12:0] OFF_ENABLE_MASK = 13'h1088;
    localparam logic [12:0] OFF_RAW_STATUS = 13'h1090;
    localparam logic [12:0] OFF_MASKED_STATUS = 13'h1098;
    localparam logic [12:0] OFF_EVENT_FORCE = 13'h10a0;
    localparam logic [12:0] OFF_EVENT_CLEAR = 13'h10a8;

    // field layout
    localparam int LINE_LO = 16;
    localparam int LINE_HI = 31;
    localparam int NUM_LINES = 16;
    localparam int ADDR_W = 13;

    // reset values
    localparam logic [15:0] RST_LINES = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // decoded register write strobes carried together
    typedef struct packed {
        logic mask_we;
        logic force_we;
        logic clear_we;
        logic [15:0] wdata;
    } gpevs_wr_s;

    // apb access phase tracking
    typedef enum logic [1:0] {
        GPEVS_IDLE = 2'b00,
        GPEVS_SETUP = 2'b01,
        GPEVS_ACCESS = 2'b11
    } gpevs_phase_e;

endpackage

/* File: gpevs_flag.sv */
// one sticky event flag with set and clear requests
// assumes set requests and clear strobes are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module gpevs_flag (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // requests
    input wire logic set_req,
    input wire logic clr_req,
    // state
    output logic flag
);
    logic flag_reg;
    logic flag_next;

    // set wins over a simultaneous clear
    always_comb begin
        flag_next = flag_reg;
        if (set_req) begin
            flag_next = 1'b1; // RL11
        end else if (clr_req) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

    chk_set_wins: assert property ( // RL11
        @(posedge ref_clk) disable iff (!nrst)
        set_req |=> flag)
        else $error("flag not set after set request");
endmodule // gpevs_flag
`default_nettype wire

/* File: gpevs_top.sv */
// gpio event status and software-set block, apb slave
// assumes hardware events arrive as one-cycle pulses on ref_clk
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] raw flag reads one after its line event, zero otherwise
// [RL2] raw status low sixteen bits reserved, read zero
// [RL3] masked status is enable mask AND raw flags
// [RL4] masked status read-only, low half reserved, resets to zero
// [RL5] software can raise any line event through the force register
// [RL6] writing one to a force bit sets that raw flag
// [RL7] forced flag on an enabled line shows in masked status too
// [RL8] force zero bits do nothing; force is write-only, resets zero
// [RL9] enable mask bits read and write, zero masked, reset masked
// [RL10] clear one bits clear raw flags even while masked
// [RL11] simultaneous set and clear on a flag leaves it set
module gpevs_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event inputs, one-cycle pulses for io_line_16 to io_line_31
    input wire logic [15:0] line_event,
    // status toward the pending-index logic
    output logic [15:0] raw_event_status,
    output logic [15:0] masked_event_status,
    output logic [15:0] event_enable_mask,
    // level interrupt
    output logic irq
);
    gpevs_pkg::gpevs_wr_s wr;
    gpevs_pkg::gpevs_phase_e phase_reg;
    logic [15:0] mask_reg;
    logic [15:0] raw_flags;
    logic [15:0] set_req;
    logic [15:0] clr_req;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic slverr_next;
    logic acc;
    logic hit;

    // single-cycle access phase, no wait states
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = acc ? slverr_next : 1'b0;

    // phase tracking; a write is only taken right after its setup cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_reg <= gpevs_pkg::GPEVS_IDLE;
        end else begin
            case (phase_reg)
                gpevs_pkg::GPEVS_IDLE:
                    phase_reg <= psel ? gpevs_pkg::GPEVS_SETUP
                                      : gpevs_pkg::GPEVS_IDLE;
                gpevs_pkg::GPEVS_SETUP:
                    phase_reg <= gpevs_pkg::GPEVS_ACCESS;
                gpevs_pkg::GPEVS_ACCESS:
                    phase_reg <= psel ? gpevs_pkg::GPEVS_SETUP
                                      : gpevs_pkg::GPEVS_IDLE;
                default:
                    phase_reg <= gpevs_pkg::GPEVS_IDLE;
            endcase
        end
    end

    // write decode; reserved low bits are discarded
    always_comb begin
        wr.mask_we = 1'b0;
        wr.force_we = 1'b0;
        wr.clear_we = 1'b0;
        wr.wdata = pwdata[gpevs_pkg::LINE_HI:gpevs_pkg::LINE_LO];
        // a stray enable without a setup cycle before it writes nothing
        if (acc && pwrite && phase_reg == gpevs_pkg::GPEVS_SETUP) begin
            if (paddr == gpevs_pkg::OFF_ENABLE_MASK) begin
                wr.mask_we = 1'b1;
            end else if (paddr == gpevs_pkg::OFF_EVENT_FORCE) begin
                wr.force_we = 1'b1;
            end else if (paddr == gpevs_pkg::OFF_EVENT_CLEAR) begin
                wr.clear_we = 1'b1;
            end
        end
    end

    // read decode; unmapped accesses and writes to the status registers flag an error
    always_comb begin
        prdata_next = gpevs_pkg::RST_WORD;
        slverr_next = 1'b0;
        hit = 1'b1;
        if (paddr == gpevs_pkg::OFF_ENABLE_MASK) begin
            prdata_next = {mask_reg, 16'h0000}; // RL9
        end else if (paddr == gpevs_pkg::OFF_RAW_STATUS) begin
            prdata_next = {raw_flags, 16'h0000}; // RL1 RL2
        end else if (paddr == gpevs_pkg::OFF_MASKED_STATUS) begin
            prdata_next = {masked_event_status, 16'h0000}; // RL4
        end else if (paddr == gpevs_pkg::OFF_EVENT_FORCE) begin
            prdata_next = gpevs_pkg::RST_WORD; // RL8 write-only reads zero
        end else if (paddr == gpevs_pkg::OFF_EVENT_CLEAR) begin
            prdata_next = gpevs_pkg::RST_WORD;
        end else begin
            hit = 1'b0;
        end
        if (!hit) begin
            slverr_next = 1'b1;
        end else if (pwrite && (paddr == gpevs_pkg::OFF_RAW_STATUS ||
                     paddr == gpevs_pkg::OFF_MASKED_STATUS)) begin
            slverr_next = 1'b1; // status is read-only, write ignored
        end
    end

    // read data held in flops, loaded in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prdata_reg <= gpevs_pkg::RST_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= prdata_next;
        end
    end
    assign prdata = prdata_reg;

    // enable mask storage
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mask_reg <= gpevs_pkg::RST_LINES; // RL9
        end else if (wr.mask_we) begin
            mask_reg <= wr.wdata; // RL9
        end
    end

    // set from hardware or force ones; clear only from clear ones
    assign set_req = line_event | (wr.force_we ? wr.wdata : 16'h0000);
    assign clr_req = wr.clear_we ? wr.wdata : 16'h0000; // RL10

    // one sticky flag per line; zero force bits produce no request
    genvar gi;
    generate
        for (gi = 0; gi < gpevs_pkg::NUM_LINES; gi++) begin : g_line
            gpevs_flag u_flag (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .set_req(set_req[gi]), // RL5 RL6 RL8
                .clr_req(clr_req[gi]),
                .flag(raw_flags[gi]) // RL1
            );
        end
    endgenerate

    // masked view is pure gating, so a forced flag shows at once
    assign masked_event_status = mask_reg & raw_flags; // RL3 RL7
    assign raw_event_status = raw_flags;
    assign event_enable_mask = mask_reg;
    assign irq = |masked_event_status;

    // a register read in two steps: its setup cycle, then its access cycle
    sequence s_masked_setup;
        psel && !penable && !pwrite &&
            (paddr == gpevs_pkg::OFF_MASKED_STATUS);
    endsequence
    sequence s_raw_setup;
        psel && !penable && !pwrite &&
            (paddr == gpevs_pkg::OFF_RAW_STATUS);
    endsequence
    sequence s_read_access;
        acc && !pwrite;
    endsequence

    // checks sample on the bus clock and sleep through reset
    chk_force_sets: assert property ( // RL6
        @(posedge ref_clk) disable iff (!nrst)
        wr.force_we |=> ((raw_flags & $past(wr.wdata)) == $past(wr.wdata)))
        else $error("force write did not set raw flags");
    // read data must show the view as it stood at the setup edge
    chk_masked_and: assert property ( // RL3
        @(posedge ref_clk) disable iff (!nrst)
        s_masked_setup ##1 s_read_access |->
            (prdata[31:16] == $past(mask_reg & raw_flags)))
        else $error("masked read differs from mask and raw");
    chk_raw_read: assert property ( // RL1
        @(posedge ref_clk) disable iff (!nrst)
        s_raw_setup ##1 s_read_access |->
            (prdata == {$past(raw_flags), 16'h0000}))
        else $error("raw read differs from raw flags");
    chk_clear_works: assert property ( // RL10
        @(posedge ref_clk) disable iff (!nrst)
        (wr.clear_we && !(|(set_req & wr.wdata))) |=>
            ((raw_flags & $past(wr.wdata)) == 16'h0000))
        else $error("clear write left a raw flag set");
    chk_event_sets: assert property ( // RL1
        @(posedge ref_clk) disable iff (!nrst)
        (|line_event) |=>
            ((raw_flags & $past(line_event)) == $past(line_event)))
        else $error("hardware event did not set raw flag");
    chk_force_zero: assert property ( // RL8
        @(posedge ref_clk) disable iff (!nrst)
        (wr.force_we && !wr.clear_we && line_event == 16'h0000) |=>
            (raw_flags == ($past(raw_flags) | $past(wr.wdata))))
        else $error("force zero bits changed raw flags");
    chk_mask_write: assert property ( // RL9
        @(posedge ref_clk) disable iff (!nrst)
        wr.mask_we |=> (mask_reg == $past(wr.wdata)))
        else $error("mask write not stored");
    chk_mask_hold: assert property ( // RL9
        @(posedge ref_clk) disable iff (!nrst)
        !wr.mask_we |=> (mask_reg == $past(mask_reg)))
        else $error("mask changed without a mask write");
    chk_forced_masked: assert property ( // RL7
        @(posedge ref_clk) disable iff (!nrst)
        (wr.force_we && ((wr.wdata & mask_reg) != 16'h0000) && !wr.mask_we)
            |=> (masked_event_status != 16'h0000))
        else $error("forced enabled line not in masked status");
    chk_rsvd_read: assert property ( // RL2 RL4
        @(posedge ref_clk) disable iff (!nrst)
        (acc && !pwrite) |-> (prdata[15:0] == 16'h0000))
        else $error("reserved read bits not zero");
endmodule // gpevs_top
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the gpio event status and force block
// assumes gpevs_top answers apb in one access cycle, events are pulses
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq;
    logic [12:0] paddr = 13'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] line_event = 16'h0000, raw_st, msk_st, en_mask;
    logic err;
    int bad_count = 0, n_compared = 0, cycles = 0;

    gpevs_top gpevs_top_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_event(line_event), .raw_event_status(raw_st),
        .masked_event_status(msk_st), .event_enable_mask(en_mask), .irq(irq));

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    // hang guard, the whole run needs under a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one apb transfer; ev pulses line_event on the access edge
    task automatic apb(input logic w, input logic [12:0] a,
            input logic [31:0] d, input logic [15:0] ev);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        line_event <= ev;
        // wait for ready; only the hang guard ends a stuck wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        line_event <= 16'h0000;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
    endtask

    // read a register and compare data and error
    task automatic rchk(input logic [12:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 16'h0000);
        `CHK(rd, e)
        `CHK(err, 1'b0)
    endtask

    task automatic t_reset();
        rchk(gpevs_pkg::OFF_ENABLE_MASK, 32'h0000_0000);
        rchk(gpevs_pkg::OFF_RAW_STATUS, 32'h0000_0000);
        rchk(gpevs_pkg::OFF_MASKED_STATUS, 32'h0000_0000);
        rchk(gpevs_pkg::OFF_EVENT_FORCE, 32'h0000_0000);
        `CHK(irq, 1'b0)
        $display("test reset done");
    endtask

    task automatic t_mask();
        apb(1'b1, gpevs_pkg::OFF_ENABLE_MASK, 32'h5aa5_ffff, 16'h0000);
        rchk(gpevs_pkg::OFF_ENABLE_MASK, 32'h5aa5_0000);
        `CHK(en_mask, 16'h5aa5)
        $display("test mask done");
    endtask

    task automatic t_force();
        apb(1'b1, gpevs_pkg::OFF_ENABLE_MASK, 32'h0001_0000, 16'h0000);
        apb(1'b1, gpevs_pkg::OFF_EVENT_FORCE, 32'h8001_ffff, 16'h0000);
        `CHK(raw_st, 16'h8001)
        `CHK(msk_st, 16'h0001)
        `CHK(irq, 1'b1)
        apb(1'b1, gpevs_pkg::OFF_EVENT_FORCE, 32'h0000_0000, 16'h0000);
        rchk(gpevs_pkg::OFF_RAW_STATUS, 32'h8001_0000);
        apb(1'b1, gpevs_pkg::OFF_MASKED_STATUS, 32'hffff_ffff, 16'h0000);
        `CHK(err, 1'b1)
        rchk(gpevs_pkg::OFF_MASKED_STATUS, 32'h0001_0000);
        $display("test force done");
    endtask

    task automatic t_clear();
        // line 31 is masked here, clear must still work on it
        apb(1'b1, gpevs_pkg::OFF_EVENT_CLEAR, 32'h8000_0000, 16'h0000);
        `CHK(raw_st, 16'h0001)
        apb(1'b1, gpevs_pkg::OFF_EVENT_CLEAR, 32'h0001_0000, 16'h0000);
        `CHK(raw_st, 16'h0000)
        `CHK(irq, 1'b0)
        $display("test clear done");
    endtask

    task automatic t_event();
        @(posedge ref_clk);
        line_event <= 16'h0100;
        @(posedge ref_clk);
        line_event <= 16'h0000;
        @(negedge ref_clk);
        `CHK(raw_st, 16'h0100)
        `CHK(msk_st, 16'h0000)
        apb(1'b1, gpevs_pkg::OFF_ENABLE_MASK, 32'h0100_0000, 16'h0000);
        `CHK(msk_st, 16'h0100)
        `CHK(irq, 1'b1)
        rchk(gpevs_pkg::OFF_RAW_STATUS, 32'h0100_0000);
        $display("test event done");
    endtask

    task automatic t_collide();
        // clear of lines 24 and 18 meets a fresh event on line 24 and line 18
        apb(1'b1, gpevs_pkg::OFF_EVENT_CLEAR, 32'h0104_0000, 16'h0104);
        `CHK(raw_st, 16'h0104)
        apb(1'b1, gpevs_pkg::OFF_EVENT_CLEAR, 32'hffff_0000, 16'h0000);
        `CHK(raw_st, 16'h0000)
        $display("test collide done");
    endtask

    task automatic t_refuse();
        apb(1'b1, 13'h0004, 32'hffff_ffff, 16'h0000);
        `CHK(err, 1'b1)
        apb(1'b0, 13'h0004, 32'h0000_0000, 16'h0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, gpevs_pkg::OFF_RAW_STATUS, 32'hffff_ffff, 16'h0000);
        `CHK(err, 1'b1)
        `CHK(raw_st, 16'h0000)
        $display("test refuse done");
    endtask

    // reset in mid-run must bring every register and every output but pready back to zero
    task automatic t_rerst();
        apb(1'b1, gpevs_pkg::OFF_ENABLE_MASK, 32'hffff_0000, 16'h0000);
        apb(1'b1, gpevs_pkg::OFF_EVENT_FORCE, 32'hffff_0000, 16'h0000);
        rchk(gpevs_pkg::OFF_MASKED_STATUS, 32'hffff_0000);
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        `CHK(raw_st, 16'h0000)
        `CHK(msk_st, 16'h0000)
        `CHK(en_mask, 16'h0000)
        `CHK(irq, 1'b0)
        `CHK(prdata, 32'h0000_0000)
        `CHK(pslverr, 1'b0)
        rchk(gpevs_pkg::OFF_RAW_STATUS, 32'h0000_0000);
        $display("test mid-run reset done");
    endtask

    // main sequence, reset held for two cycles
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_mask();
        t_force();
        t_clear();
        t_event();
        t_collide();
        t_refuse();
        t_rerst();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
